// ==== design/cub_host.sv ====
// How it works
// - Write 64-bit expected CRC at offsets 1-4
// - Start address words at offsets 5,6, then zero
// - Stop address at offsets 8,9, zero at 10
// - Confirm with 29h, then poll until ready
// - Begin with two unlocks, Extended_function_code, then 27h
// - Chip check uses count 0004h/09h, option FFFFh
// - Bypass entry: three writes ending with 20h
// - Bypass exit writes 90h then 00h
// - Prefer commands over high-voltage bypass
// Host-side sequencer that drives the flash write and read strobes.
// Only word-mode slot addresses are produced for data phases; byte_mode
// changes unlock addresses and count codes.
module cub_host
    import cub_pkg::*;
#(
    parameter int POLL_MAX = 65535 // Poll reads after the first before giving up
)
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire cub_req_t          req_in,
    output logic                   req_ready,
    output logic                   done,
    output logic                   crc_fail,
    output logic                   timeout,
    output logic                   in_bypass,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [DATA_W-1:0]      flash_dq_out,
    output logic                   flash_dq_oe,
    input  wire logic [DATA_W-1:0] flash_dq_in,
    output logic                   flash_ce_n,
    output logic                   flash_we_n,
    output logic                   flash_oe_n
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_SETUP, ST_PULSE, ST_HOLD, ST_RSETUP, ST_RSAMPLE, ST_DONE
    } cub_state_t;

    cub_state_t  state;     // Sequencer state
    cub_req_t    req;       // Latched request
    logic [4:0]  idx;       // Slot index
    logic [2:0]  tcnt;      // Phase timer
    logic [16:0] pcnt;      // Poll read count
    logic        prev_tog;  // Toggle bit of previous poll
    logic        first_rd;  // First poll read pending
    logic [DATA_W-1:0] dq_s1; // Data synchroniser stage one
    logic [DATA_W-1:0] dq_s2; // Data synchroniser stage two
    cub_wr_t     slot;      // Current slot from table
    logic [4:0]  len;       // Sequence length
    logic        is_crc;    // Request is a CRC op

    assign is_crc = (req.op == CUB_OP_CRC_RANGE) || (req.op == CUB_OP_CRC_CHIP);

    // Slot table
    cub_seq_rom u_rom (
        .mclk (mclk),
        .rst  (rst),
        .req  (req),
        .idx  (idx),
        .wr   (slot),
        .len  (len)
    );

    // Input data synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // Main sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            req      <= '0;
            idx      <= 5'd0;
            tcnt     <= 3'd0;
            pcnt     <= 17'd0;
            prev_tog <= 1'b0;
            first_rd <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Accept a new request
                    if (req_valid) begin
                        req   <= req_in;
                        idx   <= 5'd0;
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // Table output settles one cycle after index
                    tcnt  <= 3'd0;
                    state <= ST_SETUP;
                end
                ST_SETUP: begin
                    tcnt <= tcnt + 3'd1;
                    if (tcnt == 3'(CYC_SETUP - 1)) begin
                        tcnt  <= 3'd0;
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    tcnt <= tcnt + 3'd1;
                    if (tcnt == 3'(CYC_PULSE - 1)) begin
                        tcnt  <= 3'd0;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    tcnt <= tcnt + 3'd1;
                    if (tcnt == 3'(CYC_HOLD - 1)) begin
                        tcnt <= 3'd0;
                        if (idx == len - 5'd1) begin
                            // After confirm, go poll for a CRC op
                            pcnt     <= 17'd0;
                            first_rd <= 1'b1;
                            state    <= is_crc ? ST_RSETUP : ST_DONE;
                        end else begin
                            idx   <= idx + 5'd1;
                            state <= ST_FETCH;
                        end
                    end
                end
                ST_RSETUP: begin
                    // Hold read strobe long enough for synchroniser
                    tcnt <= tcnt + 3'd1;
                    if (tcnt == 3'd4) begin
                        tcnt  <= 3'd0;
                        state <= ST_RSAMPLE;
                    end
                end
                ST_RSAMPLE: begin
                    // Ready once toggle bit stops toggling
                    prev_tog <= dq_s2[POLL_TOGGLE];
                    first_rd <= 1'b0;
                    pcnt     <= pcnt + 17'd1;
                    if (!first_rd && (dq_s2[POLL_TOGGLE] == prev_tog))
                        state <= ST_DONE;
                    else if (pcnt == 17'(POLL_MAX))
                        state <= ST_DONE;
                    else
                        state <= ST_RSETUP;
                end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Result flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            done     <= 1'b0;
            crc_fail <= 1'b0;
            timeout  <= 1'b0;
        end else begin
            done <= (state == ST_DONE);
            if (state == ST_IDLE && req_valid) begin
                crc_fail <= 1'b0;
                timeout  <= 1'b0;
            end else if (state == ST_RSAMPLE) begin
                crc_fail <= dq_s2[POLL_ERR_BIT];
                timeout  <= (pcnt == 17'(POLL_MAX)) &&
                            (first_rd || dq_s2[POLL_TOGGLE] != prev_tog);
            end
        end
    end

    // Bypass tracking from issued commands
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            in_bypass <= 1'b0;
        else if (state == ST_DONE && req.op == CUB_OP_BYP_ENTER)
            in_bypass <= 1'b1;
        else if (state == ST_DONE && req.op == CUB_OP_BYP_EXIT)
            in_bypass <= 1'b0;
    end

    // Pin drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flash_addr   <= '0;
            flash_dq_out <= '0;
            flash_dq_oe  <= 1'b0;
            flash_ce_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            req_ready    <= 1'b0;
        end else begin
            req_ready   <= (state == ST_IDLE) && !req_valid;
            flash_ce_n  <= !(state inside {ST_SETUP, ST_PULSE, ST_HOLD, ST_RSETUP, ST_RSAMPLE});
            flash_we_n  <= !(state == ST_PULSE);
            // Output enable drops after each sample so every poll is a read of its own
            flash_oe_n  <= !(state == ST_RSETUP);
            flash_dq_oe <= state inside {ST_SETUP, ST_PULSE, ST_HOLD};
            if (state inside {ST_RSETUP, ST_RSAMPLE})
                flash_addr <= '0;
            else
                flash_addr <= slot.addr;
            flash_dq_out <= slot.data;
        end
    end

    // Write strobe only inside chip enable
    we_in_ce_a: assert property (@(posedge mclk) disable iff (rst)
        !flash_we_n |-> !flash_ce_n) else $error("write strobe outside enable");
    no_contention_a: assert property (@(posedge mclk) disable iff (rst)
        !(flash_dq_oe && !flash_oe_n)) else $error("bus contention");
    pulse_len_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
        else $error("write pulse length wrong");
    data_stable_a: assert property (@(posedge mclk) disable iff (rst)
        !flash_we_n && $past(!flash_we_n) |-> $stable(flash_dq_out))
        else $error("data moved in pulse");
    byp_exit_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_DONE && req.op == CUB_OP_BYP_EXIT |=> !in_bypass)
        else $error("bypass flag not cleared");
    byp_enter_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_DONE && req.op == CUB_OP_BYP_ENTER |=> in_bypass)
        else $error("bypass flag not set");
    crc_polls_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_HOLD && tcnt == 3'(CYC_HOLD - 1) && idx == len - 5'd1 && is_crc
        |=> state == ST_RSETUP) else $error("no poll after confirm");
    err_bit_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_RSAMPLE |=> crc_fail == $past(dq_s2[POLL_ERR_BIT]))
        else $error("error bit not captured");
endmodule : cub_host

// ==== design/cub_pkg.sv ====
package cub_pkg;
    // Bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;

    // Command codes
    localparam logic [15:0] UNLOCK1_DATA    = 16'h00aa;
    localparam logic [15:0] UNLOCK2_DATA    = 16'h0055;
    localparam logic [15:0] EXT_FUNC_CODE   = 16'h00eb; // extended_function_code
    localparam logic [15:0] CRC_SUB_CODE    = 16'h0027;
    localparam logic [15:0] CRC_CONFIRM     = 16'h0029;
    localparam logic [15:0] BYPASS_ENTER    = 16'h0020;
    localparam logic [15:0] BYPASS_RST1     = 16'h0090;
    localparam logic [15:0] BYPASS_RST2     = 16'h0000;
    localparam logic [15:0] CNT_RANGE_WORD  = 16'h000a;
    localparam logic [15:0] CNT_RANGE_BYTE  = 16'h0015;
    localparam logic [15:0] CNT_CHIP_WORD   = 16'h0004;
    localparam logic [15:0] CNT_CHIP_BYTE   = 16'h0009;
    localparam logic [15:0] OPT_RANGE       = 16'hfffe;
    localparam logic [15:0] OPT_CHIP        = 16'hffff;

    // Unlock addresses, word mode and byte mode
    localparam logic [23:0] UNL1_ADDR_W = 24'h000555;
    localparam logic [23:0] UNL2_ADDR_W = 24'h0002aa;
    localparam logic [23:0] UNL1_ADDR_B = 24'h000aaa;
    localparam logic [23:0] UNL2_ADDR_B = 24'h000555;

    // Polling status bit positions
    localparam int POLL_ERR_BIT   = 5; // polling_error_bit
    localparam int POLL_TOGGLE    = 6;

    // Bus cycle timing: cycles of mclk per phase
    localparam int CYC_SETUP = 2;
    localparam int CYC_PULSE = 2;
    localparam int CYC_HOLD  = 2;

    // Plan slot content
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
    } cub_wr_t;

    // User commands
    typedef enum logic [1:0] {
        CUB_OP_CRC_RANGE,
        CUB_OP_CRC_CHIP,
        CUB_OP_BYP_ENTER,
        CUB_OP_BYP_EXIT
    } cub_op_t;

    // Request bundle
    typedef struct packed {
        cub_op_t     op;
        logic        byte_mode;
        logic [63:0] crc;
        logic [31:0] start_addr;
        logic [31:0] stop_addr;
    } cub_req_t;
endpackage : cub_pkg

// ==== design/cub_seq_rom.sv ====
// Builds each bus write of a command sequence from the request; read data registered
module cub_seq_rom
    import cub_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rst,
    input  wire cub_req_t req,
    input  wire logic [4:0] idx,
    output cub_wr_t       wr,
    output logic [4:0]    len
);
    cub_wr_t    next_wr;  // Combinational slot
    logic [4:0] next_len; // Sequence length

    // Slot decode
    always_comb begin
        next_wr  = '0;
        next_len = 5'd0;
        if (req.op == CUB_OP_BYP_EXIT) begin
            next_len = 5'd2;
            next_wr.data = (idx == 5'd0) ? BYPASS_RST1 : BYPASS_RST2;
        end else begin
            if (req.op == CUB_OP_BYP_ENTER)
                next_len = 5'd3;
            else if (req.op == CUB_OP_CRC_CHIP)
                next_len = 5'd11;
            else
                next_len = 5'd17;
            // Slot sequence for word and byte mode: unlock, unlock, code, sub, count, option
            case (idx)
                5'd0: begin
                    next_wr.addr = req.byte_mode ? UNL1_ADDR_B : UNL1_ADDR_W;
                    next_wr.data = UNLOCK1_DATA;
                end
                5'd1: begin
                    next_wr.addr = req.byte_mode ? UNL2_ADDR_B : UNL2_ADDR_W;
                    next_wr.data = UNLOCK2_DATA;
                end
                5'd2: begin
                    // Bypass entry goes to the unlock address, the function code to zero
                    if (req.op == CUB_OP_BYP_ENTER)
                        next_wr.addr = req.byte_mode ? UNL1_ADDR_B : UNL1_ADDR_W;
                    else
                        next_wr.addr = 24'h000000;
                    next_wr.data = (req.op == CUB_OP_BYP_ENTER) ? BYPASS_ENTER
                                                               : EXT_FUNC_CODE;
                end
                5'd3: next_wr.data = CRC_SUB_CODE;
                5'd4: begin
                    if (req.op == CUB_OP_CRC_CHIP)
                        next_wr.data = req.byte_mode ? CNT_CHIP_BYTE : CNT_CHIP_WORD;
                    else
                        next_wr.data = req.byte_mode ? CNT_RANGE_BYTE : CNT_RANGE_WORD;
                end
                5'd5: next_wr.data = (req.op == CUB_OP_CRC_CHIP) ? OPT_CHIP : OPT_RANGE;
                5'd6: next_wr = '{addr: 24'h000001, data: req.crc[15:0]};
                5'd7: next_wr = '{addr: 24'h000002, data: req.crc[31:16]};
                5'd8: next_wr = '{addr: 24'h000003, data: req.crc[47:32]};
                5'd9: next_wr = '{addr: 24'h000004, data: req.crc[63:48]};
                5'd10: begin
                    if (req.op == CUB_OP_CRC_CHIP)
                        next_wr.data = CRC_CONFIRM;
                    else
                        next_wr = '{addr: 24'h000005, data: req.start_addr[15:0]};
                end
                5'd11: next_wr = '{addr: 24'h000006, data: req.start_addr[31:16]};
                5'd12: next_wr = '{addr: 24'h000007, data: 16'h0000};
                5'd13: next_wr = '{addr: 24'h000008, data: req.stop_addr[15:0]};
                5'd14: next_wr = '{addr: 24'h000009, data: req.stop_addr[31:16]};
                5'd15: next_wr = '{addr: 24'h00000a, data: 16'h0000};
                5'd16: next_wr.data = CRC_CONFIRM;
                default: next_wr = '0;
            endcase
        end
    end

    // Registered read port
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr  <= '0;
            len <= 5'd0;
        end else begin
            wr  <= next_wr;
            len <= next_len;
        end
    end
endmodule : cub_seq_rom

// ==== test/crc_check_and_unlock_bypass_test.sv ====
// Drives host requests and checks pins, flags and the write log of the flash model
module crc_check_and_unlock_bypass_test;
    import cub_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [63:0] GOOD = 64'h0123_4567_89ab_cdef; // Matches the model checksum

    logic        mclk      = 1'b0;     // 20 MHz clock
    logic        rst       = 1'b1;     // Reset
    logic        req_valid = 1'b0;     // Request strobe
    cub_req_t    req_in    = '0;       // Request bundle
    logic        accel_hv  = 1'b0;     // Bypass by command only
    logic        slow      = 1'b0;     // Model answers slowly
    logic        req_ready, done, crc_fail, timeout, in_bypass;
    logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
    logic [23:0] flash_addr;           // Flash address
    logic [15:0] flash_dq_out;         // Host data out
    logic [15:0] flash_dq_in;          // Wire seen by host
    int          n_errors  = 0;        // Mismatches
    int          tests_run = 0;        // Comparisons

    // Clock
    always #25 mclk = ~mclk;

    cub_host #(.POLL_MAX(8)) dut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req_in(req_in), .req_ready(req_ready), .done(done), .crc_fail(crc_fail),
        .timeout(timeout), .in_bypass(in_bypass), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));

    cub_flash_model #(.COMPUTED_CRC(GOOD)) model (.mclk(mclk), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .accel_hv(accel_hv), .slow(slow));

    // Verdict and end of run
    task automatic finish_test;
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // Compare and count
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One expected write
    function automatic cub_wr_t wr_of(input logic [23:0] a, input logic [15:0] d);
        return cub_wr_t'{a, d};
    endfunction : wr_of

    // Runs one request and checks the writes it produced and the flags
    task automatic scen(input cub_op_t op, input logic bm, input logic [63:0] crc,
                        input logic [31:0] sa, input logic [31:0] so,
                        input logic fail, input logic to, input logic byp, input int runs);
        cub_wr_t     e [$];
        int          k;
        int          r0;
        logic [23:0] a1;
        logic [23:0] a2;
        r0 = model.n_runs;
        a1 = bm ? 24'h000aaa : 24'h000555;
        a2 = bm ? 24'h000555 : 24'h0002aa;
        model.wr_log.delete();
        @(negedge mclk);
        chk("req_ready idle", req_ready, 1'b1);
        req_in = '{op: op, byte_mode: bm, crc: crc, start_addr: sa, stop_addr: so};
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        chk("req_ready busy", req_ready, 1'b0);
        for (k = 0; k < 4000 && done !== 1'b1; k++) begin
            @(negedge mclk);
        end
        if (k == 4000) begin
            chk("done", 1'b0, 1'b1);
            finish_test();
        end
        if (op == CUB_OP_BYP_EXIT) begin
            e.push_back(wr_of(24'h0, 16'h0090));
            e.push_back(wr_of(24'h0, 16'h0000));
        end else begin
            e.push_back(wr_of(a1, 16'h00aa));
            e.push_back(wr_of(a2, 16'h0055));
        end
        if (op == CUB_OP_BYP_ENTER) begin
            e.push_back(wr_of(a1, 16'h0020));
        end
        if (op == CUB_OP_CRC_CHIP || op == CUB_OP_CRC_RANGE) begin
            e.push_back(wr_of(24'h0, 16'h00eb));
            e.push_back(wr_of(24'h0, 16'h0027));
            if (op == CUB_OP_CRC_CHIP) begin
                e.push_back(wr_of(24'h0, bm ? 16'h0009 : 16'h0004));
                e.push_back(wr_of(24'h0, 16'hffff));
            end else begin
                e.push_back(wr_of(24'h0, bm ? 16'h0015 : 16'h000a));
                e.push_back(wr_of(24'h0, 16'hfffe));
            end
            for (int n = 0; n < 4; n++) begin
                e.push_back(wr_of(24'(n + 1), crc[16*n +: 16]));
            end
            if (op == CUB_OP_CRC_RANGE) begin
                e.push_back(wr_of(24'h5, sa[15:0]));
                e.push_back(wr_of(24'h6, sa[31:16]));
                e.push_back(wr_of(24'h7, 16'h0000));
                e.push_back(wr_of(24'h8, so[15:0]));
                e.push_back(wr_of(24'h9, so[31:16]));
                e.push_back(wr_of(24'ha, 16'h0000));
            end
            e.push_back(wr_of(24'h0, 16'h0029));
        end
        chk("write count", model.wr_log.size(), e.size());
        foreach (e[i]) chk("write", model.wr_log[i], e[i]);
        chk("crc_fail", crc_fail, fail);
        chk("timeout", timeout, to);
        chk("in_bypass", in_bypass, byp);
        chk("model bypass", model.bypass, byp);
        chk("check runs", model.n_runs - r0, runs);
    endtask : scen

    // Main sequence
    initial begin
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        scen(CUB_OP_CRC_CHIP, 1'b0, GOOD, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1);
        scen(CUB_OP_CRC_CHIP, 1'b1, ~GOOD, 32'h0, 32'h0, 1'b1, 1'b0, 1'b0, 1);
        scen(CUB_OP_CRC_RANGE, 1'b1, GOOD, 32'h0001_2345, 32'h0002_0000,
             1'b0, 1'b0, 1'b0, 1);
        scen(CUB_OP_CRC_RANGE, 1'b0, ~GOOD, 32'h0000_1000, 32'h0000_1000,
             1'b0, 1'b0, 1'b0, 0);
        scen(CUB_OP_BYP_ENTER, 1'b0, GOOD, 32'h0, 32'h0, 1'b0, 1'b0, 1'b1, 0);
        scen(CUB_OP_BYP_EXIT, 1'b0, GOOD, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0, 0);
        slow = 1'b1;
        scen(CUB_OP_CRC_CHIP, 1'b0, GOOD, 32'h0, 32'h0, 1'b0, 1'b1, 1'b0, 1);
        finish_test();
    end
endmodule : crc_check_and_unlock_bypass_test

// ==== test/cub_flash_model.sv ====
// Behavioural flash: decodes command writes, answers reads with status or array data
module cub_flash_model
    import cub_pkg::*;
#(
    parameter logic [63:0] COMPUTED_CRC = 64'h0123_4567_89ab_cdef, // Stands for the array checksum
    parameter logic [15:0] ARRAY_WORD   = 16'h5a0f                 // Array content, any address
)
(
    input  wire logic              mclk,
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic [DATA_W-1:0] flash_dq_out,
    input  wire logic              flash_dq_oe,
    output logic      [DATA_W-1:0] flash_dq_in,
    input  wire logic              flash_ce_n,
    input  wire logic              flash_we_n,
    input  wire logic              flash_oe_n,
    input  wire logic              accel_hv,
    input  wire logic              slow
);
    timeunit 1ns;
    timeprecision 1ps;

    cub_wr_t     wr_log [$];             // Every write seen, read by the bench
    logic [15:0] slot [1:10];            // Command words by offset
    logic [15:0] prev1   = 16'h0000;     // Last write data
    logic [15:0] prev2   = 16'h0000;     // Write data before that
    logic [15:0] opt     = 16'h0000;     // Last header word at offset 0
    logic        hdr     = 1'b0;         // Extended CRC header seen
    logic        byp_cmd = 1'b0;         // Bypass entered by command
    logic        busy    = 1'b0;         // Check in progress
    logic        err     = 1'b0;         // Check failed
    logic        tog     = 1'b0;         // Toggle bit
    logic        rd_q    = 1'b0;         // Read strobe of last cycle
    logic [15:0] last    = 16'h0000;     // Last wire value
    logic        bypass;                 // Bypass by command or high voltage
    int          n_poll  = 0;            // Reads while busy
    int          n_runs  = 0;            // Checks started

    assign bypass = byp_cmd | accel_hv;

    // Write decoder on the rising write strobe
    always @(posedge flash_we_n) begin
        if (!flash_ce_n) begin
            wr_log.push_back(cub_wr_t'{flash_addr, flash_dq_out});
            if (bypass) begin
                // Only bypass reset acts; other writes are left alone
                if (prev1 == 16'h0090 && flash_dq_out == 16'h0000) begin
                    byp_cmd = 1'b0;
                end
                // Program and erase take no unlocks here and are not modelled
            end else if (prev2 == 16'h00aa && prev1 == 16'h0055 && flash_dq_out == 16'h0020) begin
                byp_cmd = 1'b1;
            end else if (prev1 == 16'h00eb && flash_dq_out == 16'h0027) begin
                hdr = 1'b1;
                err = 1'b0;
            end else if (hdr && flash_addr != 0 && flash_addr <= 10) begin
                slot[flash_addr] = flash_dq_out;
            end else if (hdr && flash_dq_out == 16'h0029) begin
                hdr = 1'b0;
                // Whole chip, or a range whose stop lies above its start
                if (opt == 16'hffff || {slot[9], slot[8]} > {slot[6], slot[5]}) begin
                    busy = 1'b1;
                    n_poll = 0;
                    n_runs++;
                    err = {slot[4], slot[3], slot[2], slot[1]} != COMPUTED_CRC;
                end
            end else if (hdr) begin
                opt = flash_dq_out;
            end
            prev2 = prev1;
            prev1 = flash_dq_out;
        end
    end

    // Leaving high voltage drops bypass as well
    always @(negedge accel_hv) begin
        byp_cmd = 1'b0;
    end

    // Counts finished reads while busy; remembers the wire for the idle pattern
    always @(posedge mclk) begin
        if (rd_q && (flash_ce_n || flash_oe_n) && busy) begin
            tog = ~tog;
            n_poll++;
            busy = n_poll < (slow ? 40 : 3);
        end
        rd_q = !flash_ce_n && !flash_oe_n;
        last = flash_dq_in;
    end

    // Status while busy or failed, array data otherwise; released wire flips each cycle
    assign flash_dq_in = flash_dq_oe ? flash_dq_out :
                         (!flash_ce_n && !flash_oe_n) ?
                         ((busy || err) ? {9'h000, tog, err, 5'h00} : ARRAY_WORD) :
                         ~last;
endmodule : cub_flash_model
